// *** logic/fts_fan_status.sv ***
// fts_fan_status: one fan status register with live and latched bits.
// assumes: pins synchronous to clk_i; wr_i is a one-cycle write strobe.
`timescale 1ns/1ns
module fts_fan_status
	import fts_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	// fan pins
	input  wire fts_fan_pins_t        pins_i,
	// register write
	input  wire logic                 wr_i,
	input  wire logic [REG_W-1:0]     wdata_i,
	// status and events
	output logic      [REG_W-1:0]     status_o,
	output fts_fan_evt_t              evt_o
);

	logic seen_reg;
	logic prev_absent_reg;
	logic prev_fault_n_reg;
	logic gone_l_reg;
	logic fault_l_reg;
	logic tach_l_reg;
	logic ins_l_reg;
	logic sleep_reg;
	logic prio_reg;
	logic monitor;

	// edges are valid only once a previous sample exists
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			seen_reg         <= 1'b0;
			prev_absent_reg  <= 1'b0;
			prev_fault_n_reg <= 1'b1;
		end else begin
			seen_reg         <= 1'b1;
			prev_absent_reg  <= pins_i.absent;
			prev_fault_n_reg <= pins_i.fault_n;
		end
	end

	assign monitor = ~sleep_reg & ~pins_i.absent;

	always_comb begin
		evt_o.gone     = seen_reg & pins_i.absent & ~prev_absent_reg;
		evt_o.inserted = seen_reg & ~pins_i.absent & prev_absent_reg;
		evt_o.fault    = seen_reg & monitor & ~pins_i.fault_n
			& prev_fault_n_reg;
		evt_o.tach     = monitor & pins_i.tach_fault;
	end

	// latched bits: an event sets, a written zero clears, set wins
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			gone_l_reg  <= 1'b0;
			fault_l_reg <= 1'b0;
			tach_l_reg  <= 1'b0;
			ins_l_reg   <= 1'b0;
		end else begin
			gone_l_reg  <= evt_o.gone
				| (gone_l_reg & ~(wr_i & ~wdata_i[FS_GONE_L]));
			fault_l_reg <= evt_o.fault | (~pins_i.absent & fault_l_reg
				& ~(wr_i & ~wdata_i[FS_FAULT_L]));
			tach_l_reg  <= evt_o.tach | (~pins_i.absent & tach_l_reg
				& ~(wr_i & ~wdata_i[FS_TACH_L]));
			ins_l_reg   <= evt_o.inserted
				| (ins_l_reg & ~(wr_i & ~wdata_i[FS_INS_L]));
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sleep_reg <= 1'b0;
			prio_reg  <= 1'b0;
		end else if (wr_i) begin
			sleep_reg <= wdata_i[FS_SLEEP];
			prio_reg  <= wdata_i[FS_HP_PRIO];
		end
	end

	always_comb begin
		status_o             = ZERO_REG;
		status_o[FS_ABSENT]  = pins_i.absent;
		status_o[FS_GONE_L]  = gone_l_reg;
		status_o[FS_FAULT]   = ~pins_i.fault_n;
		status_o[FS_FAULT_L] = fault_l_reg;
		status_o[FS_SLEEP]   = sleep_reg;
		status_o[FS_HP_PRIO] = prio_reg;
		status_o[FS_TACH_L]  = tach_l_reg;
		status_o[FS_INS_L]   = ins_l_reg;
	end

endmodule

// *** logic/fts_pkg.sv ***
// fts_pkg: register map, field positions, reset values and carrier types
// for the fan and temperature status register bank.
// assumes: one 100 MHz clock, APB with 32-bit data, one word per register.
package fts_pkg;

	// bus shape
	localparam int ADDR_W   = 12;
	localparam int DATA_W   = 32;
	localparam int REG_W    = 8;
	localparam int IDX_W    = 8;
	localparam int NUM_FANS = 2;
	localparam int NUM_TEMP = 3;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_GSTAT   = 8'h00;
	localparam logic [IDX_W-1:0] IDX_PINCAP  = 8'h04;
	localparam logic [IDX_W-1:0] IDX_SENS    = 8'h06;
	localparam logic [IDX_W-1:0] IDX_FAN1    = 8'h10;
	localparam logic [IDX_W-1:0] IDX_FAN2    = 8'h11;
	localparam logic [IDX_W-1:0] IDX_OFS_L   = 8'h30;
	localparam logic [IDX_W-1:0] IDX_OFS_R1  = 8'h31;
	localparam logic [IDX_W-1:0] IDX_OFS_R2  = 8'h32;
	localparam logic [IDX_W-1:0] IDX_IRQ_ST  = 8'h60;
	localparam logic [IDX_W-1:0] IDX_IRQ_MSK = 8'h61;

	// reset values
	localparam logic [REG_W-1:0] PINCAP_RST  = 8'h7F;
	localparam logic [REG_W-1:0] OFS_RST     = 8'h00;
	localparam logic [REG_W-1:0] IRQ_MSK_RST = 8'h00;
	localparam logic [REG_W-1:0] ZERO_REG    = 8'h00;

	// fan status fields
	localparam int FS_ABSENT  = 0;
	localparam int FS_GONE_L  = 1;
	localparam int FS_FAULT   = 2;
	localparam int FS_FAULT_L = 3;
	localparam int FS_SLEEP   = 4;
	localparam int FS_HP_PRIO = 5;
	localparam int FS_TACH_L  = 6;
	localparam int FS_INS_L   = 7;

	// sensor installed fields
	localparam int SENS_LOCAL = 0;
	localparam int SENS_R1    = 1;
	localparam int SENS_R2    = 2;

	// global status fan event bit
	localparam int GSTAT_FAN_EVT = 6;

	// interrupt status: four events per fan, fan n at bit 4*n
	localparam int IRQ_PER_FAN = 4;

	typedef struct packed {
		logic absent;
		logic fault_n;
		logic tach_fault;
	} fts_fan_pins_t;

	typedef struct packed {
		logic tach;
		logic fault;
		logic inserted;
		logic gone;
	} fts_fan_evt_t;

	typedef enum logic [1:0] {
		SPEED_NORMAL,
		SPEED_ALARM,
		SPEED_HOTPLUG,
		SPEED_STOP
	} fts_speed_t;

endpackage

// *** logic/fts_regs.sv ***
// fts_regs: fan and temperature status register bank on APB.
// assumes: APB3 master, pins synchronous to clk_i, straps stable at reset.
//
// Operation
// - pin capability register is read-only 7Fh: pins zero to six supported.
// - reserved bits in these registers are read-only and read zero.
// - sensor installed bit zero is always one for the local sensor.
// - sensor bits one and two show remote diodes, caught at power-up.
// - fan status bit zero follows the absent pin live.
// - bit one latches fan removal until software writes zero.
// - bit two reads the inverse of the fault pin.
// - bit three latches fault edge; written zero or fan absent clears.
// - sleep bit four stops the fan and suppresses its fault monitoring.
// - asleep fan with alarm enable goes to alarm speed on overtemp.
// - hot-plug and alarm both: bit five picks hot-plug, else alarm.
// - bit six latches tach fault; written zero or fan absent clears.
// - bit seven latches fan insertion until software writes zero.
// - a newly hot-plugged fan runs at normal speed.
// - fan status at 10h serves fan one, 11h fan two.
// - each channel has an 8-bit offset, reset zero, added to its temp.
// - offsets at 30h local, 31h remote one, 32h remote two.
// - global fan event bit is OR of latched bits 1,3,6,7 of both fans.
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
module fts_regs
	import fts_pkg::*;
(
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         sys_rst_i,
	// apb slave
	input  wire logic                         psel_i,
	input  wire logic                         penable_i,
	input  wire logic                         pwrite_i,
	input  wire logic [ADDR_W-1:0]            paddr_i,
	input  wire logic [DATA_W-1:0]            pwdata_i,
	output logic      [DATA_W-1:0]            prdata_o,
	output logic                              pready_o,
	output logic                              pslverr_o,
	// fan pins, fan one at index 0
	input  wire fts_fan_pins_t [NUM_FANS-1:0] fan_pins_i,
	// speed requests from the fault and hot-plug logic
	input  wire logic [NUM_FANS-1:0]          overtemp_i,
	input  wire logic [NUM_FANS-1:0]          hotplug_req_i,
	input  wire logic [NUM_FANS-1:0]          sleep_alarm_en_i,
	// remote diode detect straps
	input  wire logic                         remote_diode_one_i,
	input  wire logic                         remote_diode_two_i,
	// temperatures: local, remote one, remote two
	input  wire logic [NUM_TEMP-1:0][REG_W-1:0] temp_raw_i,
	output logic      [NUM_TEMP-1:0][REG_W-1:0] temp_adj_o,
	// fan speed selection
	output fts_speed_t [NUM_FANS-1:0]         fan_speed_o,
	// interrupt
	output logic                              irq_o
);

	localparam int IRQ_W = NUM_FANS * IRQ_PER_FAN;

	// saturation limits of a signed temperature byte
	localparam logic [REG_W-1:0] TEMP_POS_MAX = 8'h7F;
	localparam logic [REG_W-1:0] TEMP_NEG_MAX = 8'h80;

	// true when the word address matches a register index
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [IDX_W-1:0] idx);
		hit = (a[ADDR_W-1:2] == {2'b00, idx});
	endfunction

	// signed add of temperature and offset, saturating at the ends
	function automatic logic [REG_W-1:0] sat_add(
		input logic [REG_W-1:0] t, input logic [REG_W-1:0] o);
		logic [REG_W-1:0] s;
		s = t + o;
		if (t[REG_W-1] == o[REG_W-1] && s[REG_W-1] != t[REG_W-1]) begin
			s = t[REG_W-1] ? TEMP_NEG_MAX : TEMP_POS_MAX;
		end
		sat_add = s;
	endfunction

	// speed choice for one fan
	function automatic fts_speed_t speed_pick(input logic sleep,
		input logic sl_alarm, input logic ot, input logic hp_req,
		input logic prio, input logic ins_l);
		logic hp;
		hp = hp_req & ~ins_l;
		if (sleep) begin
			speed_pick = (sl_alarm & ot) ? SPEED_ALARM : SPEED_STOP;
		end else if (ot & hp) begin
			speed_pick = prio ? SPEED_HOTPLUG : SPEED_ALARM;
		end else if (ot) begin
			speed_pick = SPEED_ALARM;
		end else if (hp) begin
			speed_pick = SPEED_HOTPLUG;
		end else begin
			speed_pick = SPEED_NORMAL;
		end
	endfunction

	logic                         pready_reg;
	logic [DATA_W-1:0]            prdata_reg;
	logic                         pslverr_reg;
	logic                         access;
	logic                         wr_en;
	logic                         rd_en;
	logic [REG_W-1:0]             wbyte;
	logic [REG_W-1:0]             rd_data;
	logic                         rd_valid;

	logic                         strap_done_reg;
	logic [REG_W-1:0]             sens_reg;
	logic [NUM_TEMP-1:0][REG_W-1:0] ofs_reg;
	logic [NUM_TEMP-1:0][REG_W-1:0] temp_adj_reg;
	logic [IRQ_W-1:0]             irq_st_reg;
	logic [IRQ_W-1:0]             irq_st_next;
	logic [IRQ_W-1:0]             irq_msk_reg;
	logic                         irq_reg;
	fts_speed_t [NUM_FANS-1:0]    speed_reg;

	logic [NUM_FANS-1:0]          fan_wr;
	logic [NUM_FANS-1:0][REG_W-1:0] fan_status;
	fts_fan_evt_t [NUM_FANS-1:0]  fan_evt;
	logic [IRQ_W-1:0]             evt_bits;
	logic                         fan_evt_any;
	logic [IDX_W-1:0]             fan_idx [NUM_FANS];

	assign fan_idx[0] = IDX_FAN1;
	assign fan_idx[1] = IDX_FAN2;

	// bus handshake: one wait cycle in the access phase
	assign access = psel_i & penable_i;
	assign wr_en  = access & pready_reg & pwrite_i;
	assign rd_en  = access & pready_reg & ~pwrite_i;
	assign wbyte  = pwdata_i[REG_W-1:0];

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= access & ~pready_reg;
		end
	end

	// read mux; unmapped addresses answer zero with an error
	always_comb begin
		rd_data  = ZERO_REG;
		rd_valid = 1'b1;
		if (hit(paddr_i, IDX_GSTAT)) begin
			rd_data[GSTAT_FAN_EVT] = fan_evt_any;
		end else if (hit(paddr_i, IDX_PINCAP)) begin
			rd_data = PINCAP_RST;
		end else if (hit(paddr_i, IDX_SENS)) begin
			rd_data = sens_reg;
		end else if (hit(paddr_i, IDX_FAN1)) begin
			rd_data = fan_status[0];
		end else if (hit(paddr_i, IDX_FAN2)) begin
			rd_data = fan_status[1];
		end else if (hit(paddr_i, IDX_OFS_L)) begin
			rd_data = ofs_reg[0];
		end else if (hit(paddr_i, IDX_OFS_R1)) begin
			rd_data = ofs_reg[1];
		end else if (hit(paddr_i, IDX_OFS_R2)) begin
			rd_data = ofs_reg[2];
		end else if (hit(paddr_i, IDX_IRQ_ST)) begin
			rd_data = irq_st_reg;
		end else if (hit(paddr_i, IDX_IRQ_MSK)) begin
			rd_data = irq_msk_reg;
		end else begin
			rd_valid = 1'b0;
		end
	end

	// read data and error are loaded in the wait cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end else if (access & ~pready_reg) begin
			prdata_reg  <= {{(DATA_W-REG_W){1'b0}}, rd_data};
			pslverr_reg <= ~rd_valid;
		end else begin
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end
	end

	assign prdata_o  = prdata_reg;
	assign pready_o  = pready_reg;
	assign pslverr_o = pslverr_reg;

	// sensor presence caught once, on the first edge after reset release
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			strap_done_reg <= 1'b0;
			sens_reg       <= ZERO_REG;
		end else if (!strap_done_reg) begin
			strap_done_reg       <= 1'b1;
			sens_reg[SENS_LOCAL] <= 1'b1;
			sens_reg[SENS_R1]    <= remote_diode_one_i;
			sens_reg[SENS_R2]    <= remote_diode_two_i;
		end
	end

	// temperature offsets
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ofs_reg <= {NUM_TEMP{OFS_RST}};
		end else if (wr_en) begin
			if (hit(paddr_i, IDX_OFS_L)) begin
				ofs_reg[0] <= wbyte;
			end
			if (hit(paddr_i, IDX_OFS_R1)) begin
				ofs_reg[1] <= wbyte;
			end
			if (hit(paddr_i, IDX_OFS_R2)) begin
				ofs_reg[2] <= wbyte;
			end
		end
	end

	// corrected temperatures
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			temp_adj_reg <= '0;
		end else begin
			for (int c = 0; c < NUM_TEMP; c++) begin
				temp_adj_reg[c] <= sat_add(temp_raw_i[c], ofs_reg[c]);
			end
		end
	end

	assign temp_adj_o = temp_adj_reg;

	// per-fan status registers
	for (genvar f = 0; f < NUM_FANS; f++) begin : g_fan
		assign fan_wr[f] = wr_en & hit(paddr_i, fan_idx[f]);

		fts_fan_status u_fan (
			.clk_i     (clk_i),
			.sys_rst_i (sys_rst_i),
			.pins_i    (fan_pins_i[f]),
			.wr_i      (fan_wr[f]),
			.wdata_i   (wbyte),
			.status_o  (fan_status[f]),
			.evt_o     (fan_evt[f])
		);

		assign evt_bits[f*IRQ_PER_FAN +: IRQ_PER_FAN] = fan_evt[f];
	end

	// fan event summary for the global status register
	always_comb begin
		fan_evt_any = 1'b0;
		for (int f = 0; f < NUM_FANS; f++) begin
			fan_evt_any = fan_evt_any | fan_status[f][FS_GONE_L]
				| fan_status[f][FS_FAULT_L] | fan_status[f][FS_TACH_L]
				| fan_status[f][FS_INS_L];
		end
	end

	// fan speed selection
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int f = 0; f < NUM_FANS; f++) begin
				speed_reg[f] <= SPEED_NORMAL;
			end
		end else begin
			for (int f = 0; f < NUM_FANS; f++) begin
				speed_reg[f] <= speed_pick(
					fan_status[f][FS_SLEEP], sleep_alarm_en_i[f],
					overtemp_i[f], hotplug_req_i[f],
					fan_status[f][FS_HP_PRIO],
					fan_status[f][FS_INS_L]);
			end
		end
	end

	assign fan_speed_o = speed_reg;

	// interrupt status: sticky, cleared by a read, set wins over clear
	always_comb begin
		irq_st_next = irq_st_reg;
		if (rd_en && hit(paddr_i, IDX_IRQ_ST)) begin
			// only reported bits clear; an event after the data load survives
			irq_st_next = irq_st_reg & ~prdata_reg[IRQ_W-1:0];
		end
		irq_st_next = irq_st_next | evt_bits;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_st_reg <= '0;
		end else begin
			irq_st_reg <= irq_st_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_msk_reg <= IRQ_MSK_RST;
		end else if (wr_en && hit(paddr_i, IDX_IRQ_MSK)) begin
			irq_msk_reg <= wbyte;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_st_next & irq_msk_reg);
		end
	end

	assign irq_o = irq_reg;

endmodule

// *** tb/fts_fan_model.sv ***
// fts_fan_model: two cooling fans with presence, fault and tach lines.
// assumes: bench commands change just after a rising edge.
`timescale 1ns/1ns
module fts_fan_model
	import fts_pkg::*;
(
	// clock
	input  wire logic                  clk_i,
	// fan conditions
	input  wire logic [NUM_FANS-1:0]   fitted_i,
	input  wire logic [NUM_FANS-1:0]   fail_i,
	input  wire logic [NUM_FANS-1:0]   stall_i,
	// pins
	output fts_fan_pins_t [NUM_FANS-1:0] pins_o
);
	// a removed fan leaves its fault line to the pull-up
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < NUM_FANS; i++) begin
			pins_o[i].absent     <= !fitted_i[i];
			pins_o[i].fault_n    <= !(fitted_i[i] && fail_i[i]);
			pins_o[i].tach_fault <= fitted_i[i] && stall_i[i];
		end
	end
endmodule

// *** tb/fts_regs_properties.sv ***
// fts_regs_properties: port assertions for the fan status register bank.
// assumes: bound to fts_regs, one clock, straps held through each run.
`timescale 1ns/1ns
module fts_regs_properties
	import fts_pkg::*;
(
	input wire logic                         clk_i,
	input wire logic                         sys_rst_i,
	input wire logic                         psel_i,
	input wire logic                         penable_i,
	input wire logic                         pwrite_i,
	input wire logic [ADDR_W-1:0]            paddr_i,
	input wire logic [DATA_W-1:0]            prdata_o,
	input wire logic                         pready_o,
	input wire logic                         pslverr_o,
	input wire fts_fan_pins_t [NUM_FANS-1:0] fan_pins_i,
	input wire logic                         remote_diode_one_i,
	input wire logic                         remote_diode_two_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic       rd;
	logic [9:0] ix;
	assign rd = psel_i && penable_i && pready_o && !pwrite_i;
	assign ix = paddr_i[11:2];
	a_cap_value: assert property (
		rd && ix == {2'h0, IDX_PINCAP} |-> prdata_o == 32'h7F)
		else $error("pin capability read wrong");
	a_upper_zero: assert property (
		rd |-> prdata_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_local_present: assert property (
		rd && ix == {2'h0, IDX_SENS} |-> prdata_o[0] && !prdata_o[7:3])
		else $error("sensor register fixed bits wrong");
	a_diode_seen: assert property (
		rd && ix == {2'h0, IDX_SENS} |->
		prdata_o[2:1] == {remote_diode_two_i, remote_diode_one_i})
		else $error("remote diode bits wrong");
	a_absent_live: assert property (
		rd && ix == {2'h0, IDX_FAN1} |->
		prdata_o[0] == $past(fan_pins_i[0].absent))
		else $error("fan one absent bit wrong");
	a_fan_two_live: assert property (
		rd && ix == {2'h0, IDX_FAN2} |->
		prdata_o[0] == $past(fan_pins_i[1].absent))
		else $error("fan two absent bit wrong");
	a_fault_inverse: assert property (
		rd && ix == {2'h0, IDX_FAN1} |->
		prdata_o[2] == !$past(fan_pins_i[0].fault_n))
		else $error("fan one fault bit wrong");
	a_one_wait: assert property (
		psel_i && !penable_i ##1 psel_i && penable_i |->
		!pready_o ##1 pready_o)
		else $error("ready not after one wait state");
	a_ready_pulse: assert property (
		pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_err_answer: assert property (
		pslverr_o |-> pready_o)
		else $error("error outside answer cycle");
endmodule

bind fts_regs fts_regs_properties i_chk (.clk_i, .sys_rst_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
	.fan_pins_i, .remote_diode_one_i, .remote_diode_two_i);

// *** tb/tb_top.sv ***
// tb_top: directed tests of the register bank through APB.
// assumes: fts_regs with fan model on its pins, 100 MHz clock.
`timescale 1ns/1ns
module tb_top
	import fts_pkg::*;
;
	logic                           clk_i = 1'b0;
	logic                           sys_rst_i = 1'b1;
	logic                           psel_i = 1'b0;
	logic                           penable_i = 1'b0;
	logic                           pwrite_i = 1'b0;
	logic [ADDR_W-1:0]              paddr_i = '0;
	logic [DATA_W-1:0]              pwdata_i = '0;
	logic [DATA_W-1:0]              prdata_o;
	logic                           pready_o;
	logic                           pslverr_o;
	fts_fan_pins_t [NUM_FANS-1:0]   fan_pins_i;
	logic [NUM_FANS-1:0]            overtemp_i = '0;
	logic [NUM_FANS-1:0]            hotplug_req_i = '0;
	logic [NUM_FANS-1:0]            sleep_alarm_en_i = '0;
	logic                           remote_diode_one_i = 1'b0;
	logic                           remote_diode_two_i = 1'b1;
	logic [NUM_TEMP-1:0][REG_W-1:0] temp_raw_i = {8'h40, 8'h30, 8'h20};
	logic [NUM_TEMP-1:0][REG_W-1:0] temp_adj_o;
	fts_speed_t [NUM_FANS-1:0]      fan_speed_o;
	logic                           irq_o;
	logic [NUM_FANS-1:0]            fitted = 2'h3;
	logic [NUM_FANS-1:0]            fail = 2'h0;
	logic [NUM_FANS-1:0]            stall = 2'h0;
	logic                           err;
	int                             mismatches = 0;
	int                             checked = 0;

	always #5 clk_i = !clk_i;

	fts_fan_model i_fans (.clk_i, .fitted_i(fitted), .fail_i(fail),
		.stall_i(stall), .pins_o(fan_pins_i));
	fts_regs i_dut (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .fan_pins_i,
		.overtemp_i, .hotplug_req_i, .sleep_alarm_en_i, .remote_diode_one_i,
		.remote_diode_two_i, .temp_raw_i, .temp_adj_o, .fan_speed_o, .irq_o);

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic apb(input logic w, input logic [IDX_W-1:0] ix,
			input logic [7:0] wd, output logic [DATA_W-1:0] r);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= {2'h0, ix, 2'h0};
		pwdata_i <= {24'h0, wd};
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [IDX_W-1:0] ix, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, ix, 8'h00, r);
		cmp(r, e);
	endtask
	task automatic wr(input logic [IDX_W-1:0] ix, input logic [7:0] d);
		logic [31:0] r;
		apb(1'b1, ix, d, r);
	endtask

	task automatic t_const();
		logic [31:0] r;
		rdc(IDX_PINCAP, 32'h7F);
		wr(IDX_PINCAP, 8'h00);
		rdc(IDX_PINCAP, 32'h7F);
		rdc(IDX_SENS, 32'h05);
		apb(1'b0, 8'h3F, 8'h00, r);
		cmp({31'h0, err}, 32'h1);
		$display("t_const done");
	endtask
	task automatic t_ofs();
		for (int i = 0; i < 3; i++) begin
			rdc(IDX_OFS_L + 8'(i), 32'h00);
			wr(IDX_OFS_L + 8'(i), 8'h10 + 8'(i));
			rdc(IDX_OFS_L + 8'(i), 32'h10 + i);
		end
		cyc(2);
		for (int i = 0; i < 3; i++)
			cmp(temp_adj_o[i], temp_raw_i[i] + 8'h10 + 8'(i));
		wr(IDX_OFS_L, 8'h70);
		wr(IDX_OFS_R1, 8'hF0);
		cyc(2);
		cmp(temp_adj_o[0], 32'h7F);
		cmp(temp_adj_o[1], 32'h20);
		$display("t_ofs done");
	endtask
	task automatic t_plug();
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_i);
			fitted[k] <= 1'b0;
			cyc(4);
			rdc(IDX_FAN1 + 8'(k), 32'h03);
			rdc(IDX_FAN2 - 8'(k), 32'h00);
			rdc(IDX_GSTAT, 32'h40);
			wr(IDX_FAN1 + 8'(k), 8'h82);
			rdc(IDX_FAN1 + 8'(k), 32'h03);
			@(posedge clk_i);
			fitted[k] <= 1'b1;
			hotplug_req_i[k] <= 1'b1;
			cyc(4);
			rdc(IDX_FAN1 + 8'(k), 32'h82);
			cmp(fan_speed_o[k], SPEED_NORMAL);
			hotplug_req_i[k] <= 1'b0;
			wr(IDX_FAN1 + 8'(k), 8'h00);
			rdc(IDX_FAN1 + 8'(k), 32'h00);
			rdc(IDX_GSTAT, 32'h00);
		end
		$display("t_plug done");
	endtask
	task automatic t_fault();
		@(posedge clk_i);
		fail[0] <= 1'b1;
		cyc(4);
		rdc(IDX_FAN1, 32'h0C);
		fail[0] <= 1'b0;
		stall[0] <= 1'b1;
		cyc(4);
		rdc(IDX_FAN1, 32'h48);
		stall[0] <= 1'b0;
		fitted[0] <= 1'b0;
		cyc(4);
		rdc(IDX_FAN1, 32'h03);
		fitted[0] <= 1'b1;
		cyc(4);
		wr(IDX_FAN1, 8'h10);
		fail[0] <= 1'b1;
		cyc(4);
		cmp(fan_speed_o[0], SPEED_STOP);
		fail[0] <= 1'b0;
		overtemp_i[0] <= 1'b1;
		sleep_alarm_en_i[0] <= 1'b1;
		cyc(4);
		rdc(IDX_FAN1, 32'h10);
		cmp(fan_speed_o[0], SPEED_ALARM);
		wr(IDX_FAN1, 8'h20);
		hotplug_req_i[0] <= 1'b1;
		cyc(3);
		cmp(fan_speed_o[0], SPEED_HOTPLUG);
		wr(IDX_FAN1, 8'h00);
		cyc(3);
		cmp(fan_speed_o[0], SPEED_ALARM);
		overtemp_i[0] <= 1'b0;
		hotplug_req_i[0] <= 1'b0;
		sleep_alarm_en_i[0] <= 1'b0;
		$display("t_fault done");
	endtask
	task automatic t_irq();
		logic [31:0] r;
		apb(1'b0, IDX_IRQ_ST, 8'h00, r);
		rdc(IDX_IRQ_MSK, 32'h00);
		wr(IDX_IRQ_MSK, 8'h10);
		rdc(IDX_IRQ_MSK, 32'h10);
		fitted[0] <= 1'b0;
		cyc(4);
		cmp({31'h0, irq_o}, 32'h0);
		fitted[1] <= 1'b0;
		cyc(4);
		cmp({31'h0, irq_o}, 32'h1);
		rdc(IDX_IRQ_ST, 32'h11);
		cyc(2);
		cmp({31'h0, irq_o}, 32'h0);
		fitted <= 2'h3;
		cyc(4);
		rdc(IDX_IRQ_ST, 32'h22);
		cmp({31'h0, irq_o}, 32'h0);
		wr(IDX_FAN1, 8'h00);
		wr(IDX_FAN2, 8'h00);
		$display("t_irq done");
	endtask

	task automatic print_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		cyc(3);
		t_const();
		t_ofs();
		t_plug();
		t_fault();
		t_irq();
		print_verdict();
	end
	initial begin
		#200000;
		mismatches++;
		print_verdict();
	end
endmodule
